/* File: pwr_pkg.sv */
// Purpose: Constants and types for the power mode controller
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes:   Behaviour list below
//
// Behaviour
// - Four global modes: active, alternate active, sleep, hibernate.
// - In active, subsystem enables follow active template bits, writable anytime.
// - Active and alternate active each use their own template register.
// - Disabled resources have their digital clocks gated.
// - Processor may disable itself; next wakeup re-enables it.
// - Any wakeup sets mode active and enables the processor.
// - After boot the global mode is active.
// - Alternate active enables the reduced subsystem set from its template.
// - Sleep disables most resources, keeping only timing functions.
// - Sleep keeps timing running from low-speed or watch crystal clock.
// - Hibernate stops all clocks; only pin interrupt unit wakes it.
// - Core regulators enabled after power-up; firmware may clear them.
package pwr_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0]  ADDR_MODE    = 4'h0;
  localparam logic [3:0]  ADDR_ACT_TPL = 4'h4;
  localparam logic [3:0]  ADDR_ALT_TPL = 4'h8;
  localparam logic [3:0]  ADDR_REG_EN  = 4'hC;

  // ==========================================================
  // Fields and reset values
  localparam int          NSUB         = 8;
  localparam int          CPU_BIT      = 0;
  localparam int          TIMING_BIT   = 1;
  localparam int          CPU_OFF_POS  = 2;
  localparam int          XTAL_POS     = 3;
  localparam logic [7:0]  TPL_RST      = 8'hFF;
  localparam logic [1:0]  REG_EN_RST   = 2'h3;
  localparam logic [7:0]  SLEEP_KEEP   = 8'h02;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // ==========================================================
  // Modes and wake sources
  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_ALT_ACTIVE,
    MODE_SLEEP,
    MODE_HIBERNATE
  } mode_e;

  typedef struct packed {
    logic pin_interrupt_unit;
    logic central_time_wheel;
    logic comparator;
    logic i2c;
    logic rtc;
    logic low_voltage_detect;
  } wake_s;

endpackage : pwr_pkg

/* File: wake_sync.sv */
// Purpose: Three-stage synchroniser for asynchronous wake inputs
// Assumes: Inputs are levels from outside the clock domain
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ns
module wake_sync (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [5:0] async_in,
  output logic [5:0]      sync_out
);
  import pwr_pkg::*;

  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;

  // ==========================================================
  // Sync chain and agreement filter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_agree
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_out[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule : wake_sync

/* File: power_mode_controller.sv */
// Purpose: Global power mode sequencer with template-driven clock gating
// Assumes: Avalon-MM slave, one wait state per access
// Notes:   Wake sources are asynchronous levels; rising edge wakes
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module power_mode_controller (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire pwr_pkg::wake_s      wake_in,
  input  wire logic                low_speed_oscillator,
  input  wire logic                watch_crystal_clock,
  output logic [pwr_pkg::NSUB-1:0] clk_en,
  output logic                     timing_clk,
  output logic [1:0]               mode,
  output logic [1:0]               core_reg_en
);
  import pwr_pkg::*;

  // ==========================================================
  // State
  mode_e            mode_q;
  logic [NSUB-1:0]  act_tpl_q;
  logic [NSUB-1:0]  alt_tpl_q;
  logic             cpu_off_q;
  logic [1:0]       reg_en_q;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic             xtal_sel_q;
  logic [5:0]       wake_sync_w;
  logic [5:0]       wake_prev_q;
  logic [5:0]       wake_rise;
  logic             wake_ev;
  logic [NSUB-1:0]  en_d;
  logic [NSUB-1:0]  en_q;
  logic             req;
  logic             wr_go;
  logic [1:0]       slow_s1_q;
  logic [1:0]       slow_s2_q;
  logic [1:0]       slow_s3_q;
  logic [1:0]       slow_q;

  // ==========================================================
  // Wake synchroniser
  wake_sync u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (wake_in),
    .sync_out (wake_sync_w)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_prev_q <= '0;
    end else begin
      wake_prev_q <= wake_sync_w;
    end
  end

  assign wake_rise = wake_sync_w & ~wake_prev_q;

  // Hibernate accepts pin interrupt unit only
  always_comb begin
    if (mode_q == MODE_HIBERNATE) begin
      wake_ev = wake_rise[5];
    end else begin
      wake_ev = |wake_rise;
    end
  end

  // ==========================================================
  // Slow clock synchroniser, bit1 watch crystal, bit0 oscillator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_s1_q <= '0;
      slow_s2_q <= '0;
      slow_s3_q <= '0;
    end else begin
      slow_s1_q <= {watch_crystal_clock, low_speed_oscillator};
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  // Follow stage three once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_q <= '0;
    end else begin
      slow_q <= (slow_s2_q & slow_s3_q)
                | (slow_q & (slow_s2_q | slow_s3_q));
    end
  end

  // ==========================================================
  // Avalon-MM slave: waitrequest high until ack cycle
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go           = avs_write & ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (avs_read & ~ack_q) begin
      if (avs_address == ADDR_MODE) begin
        rdata_q <= {28'h000_0000, xtal_sel_q, cpu_off_q, mode_q};
      end else if (avs_address == ADDR_ACT_TPL) begin
        rdata_q <= {24'h00_0000, act_tpl_q};
      end else if (avs_address == ADDR_ALT_TPL) begin
        rdata_q <= {24'h00_0000, alt_tpl_q};
      end else if (avs_address == ADDR_REG_EN) begin
        rdata_q <= {30'h0000_0000, reg_en_q};
      end else begin
        rdata_q <= UNMAPPED_RD;
      end
    end
  end

  // ==========================================================
  // Templates and regulator enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_tpl_q <= TPL_RST;
    end else begin
      if (wr_go && avs_address == ADDR_ACT_TPL
          && avs_byteenable[0]) begin
        act_tpl_q <= avs_writedata[NSUB-1:0];
      end
      if (wake_ev) begin
        act_tpl_q[CPU_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_tpl_q <= TPL_RST;
    end else if (wr_go && avs_address == ADDR_ALT_TPL
                 && avs_byteenable[0]) begin
      alt_tpl_q <= avs_writedata[NSUB-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_en_q <= REG_EN_RST;
    end else if (wr_go && avs_address == ADDR_REG_EN
                 && avs_byteenable[0]) begin
      reg_en_q <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_sel_q <= 1'b0;
    end else if (wr_go && avs_address == ADDR_MODE
                 && avs_byteenable[0]) begin
      xtal_sel_q <= avs_writedata[XTAL_POS];
    end
  end

  // ==========================================================
  // Mode sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_ACTIVE;
    end else if (wake_ev) begin
      mode_q <= MODE_ACTIVE;
    end else if (wr_go && avs_address == ADDR_MODE
                 && avs_byteenable[0]) begin
      case (mode_q)
        MODE_ACTIVE: begin
          mode_q <= mode_e'(avs_writedata[1:0]);
        end
        MODE_ALT_ACTIVE: begin
          if (avs_writedata[1:0] != 2'h0) begin
            mode_q <= mode_e'(avs_writedata[1:0]);
          end
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  // Processor self-disable; wake wins over the write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_off_q <= 1'b0;
    end else if (wake_ev) begin
      cpu_off_q <= 1'b0;
    end else if (wr_go && avs_address == ADDR_MODE
                 && avs_byteenable[0]) begin
      cpu_off_q <= avs_writedata[CPU_OFF_POS];
    end
  end

  // ==========================================================
  // Clock enables per subsystem
  always_comb begin
    case (mode_q)
      MODE_ACTIVE: begin
        en_d = act_tpl_q;
      end
      MODE_ALT_ACTIVE: begin
        en_d = alt_tpl_q;
      end
      MODE_SLEEP: begin
        en_d = SLEEP_KEEP;
      end
      default: begin
        en_d = '0;
      end
    endcase
    if (cpu_off_q) begin
      en_d[CPU_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= TPL_RST;
    end else begin
      en_q <= en_d;
    end
  end

  assign clk_en      = en_q;
  assign mode        = mode_q;
  assign core_reg_en = reg_en_q;

  // Sleep timing source select, stopped in hibernate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timing_clk <= 1'b0;
    end else if (mode_q == MODE_HIBERNATE) begin
      timing_clk <= 1'b0;
    end else begin
      timing_clk <= xtal_sel_q ? slow_q[1] : slow_q[0];
    end
  end

  // ==========================================================
  // Checks
  property p_boot_active;
    @(posedge ref_clk) $rose(rst_n) |-> mode_q == MODE_ACTIVE;
  endproperty
  a_boot_active: assert property (p_boot_active)
    else $error("mode not active after reset");

  property p_wake_active;
    @(posedge ref_clk) disable iff (!rst_n)
      wake_ev |=> mode_q == MODE_ACTIVE && !cpu_off_q;
  endproperty
  a_wake_active: assert property (p_wake_active)
    else $error("wake did not return to active");

  property p_cpu_on_after_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      wake_ev |-> ##2 clk_en[CPU_BIT];
  endproperty
  a_cpu_on_after_wake: assert property (p_cpu_on_after_wake)
    else $error("cpu enable wrong after wake");

  property p_act_tpl;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_q == MODE_ACTIVE && !cpu_off_q |=> clk_en == $past(act_tpl_q);
  endproperty
  a_act_tpl: assert property (p_act_tpl)
    else $error("active enables differ from template");

  property p_alt_tpl;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_q == MODE_ALT_ACTIVE && !cpu_off_q
      |=> clk_en == $past(alt_tpl_q);
  endproperty
  a_alt_tpl: assert property (p_alt_tpl)
    else $error("alt active enables differ from template");

  property p_sleep_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_q == MODE_SLEEP && $stable(mode_q)
      |=> (clk_en & ~SLEEP_KEEP) == '0;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("sleep left resources enabled");

  property p_hib_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_q == MODE_HIBERNATE ##1 mode_q == MODE_HIBERNATE
      |-> clk_en == '0 && !timing_clk;
  endproperty
  a_hib_gate: assert property (p_hib_gate)
    else $error("clock running in hibernate");

  property p_low_exit;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode_q == MODE_SLEEP || mode_q == MODE_HIBERNATE) && !wake_ev
      |=> mode_q == $past(mode_q);
  endproperty
  a_low_exit: assert property (p_low_exit)
    else $error("low power mode left without wake");

  property p_reg_default;
    @(posedge ref_clk) $rose(rst_n) |-> reg_en_q == REG_EN_RST;
  endproperty
  a_reg_default: assert property (p_reg_default)
    else $error("regulators not enabled at boot");

  property p_hib_pin_only;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_q == MODE_HIBERNATE && !wake_rise[5] |=> mode_q == MODE_HIBERNATE;
  endproperty
  a_hib_pin_only: assert property (p_hib_pin_only)
    else $error("hibernate left without pin event");

  property p_alt_no_rise;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_q == MODE_ALT_ACTIVE && !wake_ev |=> mode_q != MODE_ACTIVE;
  endproperty
  a_alt_no_rise: assert property (p_alt_no_rise)
    else $error("alt active raised to active by a write");

  property p_reg_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !(wr_go && avs_address == ADDR_REG_EN) |=> $stable(reg_en_q);
  endproperty
  a_reg_hold: assert property (p_reg_hold)
    else $error("regulator enables changed without a write");

  property p_wake_tpl;
    @(posedge ref_clk) disable iff (!rst_n)
      wake_ev |=> act_tpl_q[CPU_BIT];
  endproperty
  a_wake_tpl: assert property (p_wake_tpl)
    else $error("cpu template bit not set by wake");

  property p_sleep_timing;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_q == MODE_SLEEP && $stable(mode_q) |=> clk_en[TIMING_BIT];
  endproperty
  a_sleep_timing: assert property (p_sleep_timing)
    else $error("timing enable off in sleep");

endmodule : power_mode_controller

/* File: wake_source.sv */
// Purpose: Wake event sources and slow clocks
// Assumes: Rising level on a wake line is one event
// Notes:   Pulses are long enough to pass the synchroniser
`timescale 1ns/1ns
module wake_source (
  input  wire logic      ref_clk,
  output pwr_pkg::wake_s wake_in,
  output logic           low_speed_oscillator,
  output logic           watch_crystal_clock
);
  import pwr_pkg::*;
  logic [4:0] div_q;
  initial begin
    wake_in = '0;
    div_q   = '0;
  end
  // ==========================================================
  // Free running slow clocks
  always @(posedge ref_clk) begin
    div_q <= div_q + 5'h01;
  end
  assign low_speed_oscillator = div_q[3];
  assign watch_crystal_clock  = div_q[4];
  // ==========================================================
  // One wake event on line idx, then idle
  task automatic pulse(input int idx);
    @(posedge ref_clk);
    wake_in <= wake_s'(6'h01 << idx);
    repeat (8) @(posedge ref_clk);
    wake_in <= '0;
    repeat (8) @(posedge ref_clk);
  endtask : pulse
endmodule : wake_source

/* File: power_mode_controller_tb.sv */
// Purpose: Self-checking bench for the power mode controller
// Assumes: One wait state per bus access
// Notes:   Random templates from a fixed xorshift seed
`timescale 1ns/1ns
module power_mode_controller_tb;
  import pwr_pkg::*;
  logic        ref_clk, rst_n, avs_read, avs_write;
  logic        avs_waitrequest, lso, wcc, timing_clk;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata, seed;
  logic [7:0]  clk_en, act, alt;
  logic [1:0]  mode, core_reg_en;
  wake_s       wake_in;
  int          errors, num_checks, cyc;

  power_mode_controller u_power_mode_controller (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wake_in(wake_in), .low_speed_oscillator(lso),
    .watch_crystal_clock(wcc), .clk_en(clk_en),
    .timing_clk(timing_clk), .mode(mode), .core_reg_en(core_reg_en));
  wake_source u_wake_source (
    .ref_clk(ref_clk), .wake_in(wake_in),
    .low_speed_oscillator(lso), .watch_crystal_clock(wcc));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] exp_en(input logic [1:0] m,
    input logic [7:0] a, input logic [7:0] b, input logic off);
    case (m)
      2'h0: return a & ~{7'h00, off};
      2'h1: return b;
      2'h2: return SLEEP_KEEP;
      default: return 8'h00;
    endcase
  endfunction : exp_en
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task automatic ticks(input logic sel);
    logic [4:0] hist;
    int         bad;
    hist = '0;
    bad  = 0;
    repeat (5) begin
      @(negedge ref_clk);
      hist = {hist[3:0], sel ? wcc : lso};
    end
    repeat (40) begin
      @(negedge ref_clk);
      if (timing_clk !== hist[4]) bad++;
      hist = {hist[3:0], sel ? wcc : lso};
    end
    chk(bad, 0);
  endtask : ticks
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Clock and timeout
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    seed = 32'h12ff_3136;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(mode, MODE_ACTIVE);
    chk(clk_en, TPL_RST);
    chk(core_reg_en, REG_EN_RST);
    bus(0, ADDR_MODE, 0); chk(rdata, 0);
    bus(0, ADDR_ACT_TPL, 0); chk(rdata, TPL_RST);
    bus(0, ADDR_ALT_TPL, 0); chk(rdata, TPL_RST);
    bus(0, ADDR_REG_EN, 0); chk(rdata, REG_EN_RST);
    bus(0, 4'h2, 0); chk(rdata, UNMAPPED_RD);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      act = seed[7:0] | 8'h01;
      bus(1, ADDR_ACT_TPL, {24'h00_0000, act});
      settle();
      chk(clk_en, exp_en(0, act, alt, 0));
    end
    seed = xs(seed);
    alt = seed[15:8];
    bus(1, ADDR_ALT_TPL, {24'h00_0000, alt});
    bus(1, ADDR_MODE, 32'h0000_0001);
    settle();
    chk(mode, MODE_ALT_ACTIVE);
    chk(clk_en, exp_en(1, act, alt, 0));
    bus(1, ADDR_MODE, 32'h0000_0000);
    settle();
    chk(mode, MODE_ALT_ACTIVE);
    // Supplies valid before any low-power request
    for (int i = 0; i < 6; i++) begin
      bus(1, ADDR_MODE, i[0] ? 32'h0000_000A : 32'h0000_0002);
      settle();
      chk(mode, MODE_SLEEP);
      chk(clk_en, exp_en(2, act, alt, 0));
      ticks(i[0]);
      bus(1, ADDR_MODE, 32'h0000_0000);
      settle();
      chk(mode, MODE_SLEEP);
      u_wake_source.pulse(i);
      chk(mode, MODE_ACTIVE);
      chk(clk_en, exp_en(0, act, alt, 0));
    end
    bus(1, ADDR_MODE, 32'h0000_0004);
    settle();
    chk(clk_en, exp_en(0, act, alt, 1));
    u_wake_source.pulse(4);
    chk(clk_en, exp_en(0, act, alt, 0));
    act = act & 8'hFE;
    bus(1, ADDR_ACT_TPL, {24'h00_0000, act});
    settle();
    chk(clk_en, exp_en(0, act, alt, 0));
    bus(1, ADDR_MODE, 32'h0000_0001);
    u_wake_source.pulse(1);
    act[CPU_BIT] = 1'b1;
    @(negedge ref_clk);
    chk(mode, MODE_ACTIVE);
    chk(clk_en, exp_en(0, act, alt, 0));
    bus(0, ADDR_ACT_TPL, 0);
    chk(rdata, {24'h00_0000, act});
    bus(1, ADDR_MODE, 32'h0000_0003);
    settle();
    chk(mode, MODE_HIBERNATE);
    chk(clk_en, exp_en(3, act, alt, 0));
    chk(timing_clk, 0);
    u_wake_source.pulse(3);
    chk(mode, MODE_HIBERNATE);
    u_wake_source.pulse(5);
    chk(mode, MODE_ACTIVE);
    bus(1, ADDR_REG_EN, 32'h0000_0000);
    settle();
    chk(core_reg_en, 0);
    report_and_stop();
  end
endmodule : power_mode_controller_tb
